// *** ccm_pkg.sv ***
// constants and types shared by the capture/compare array
`default_nettype none
package ccm_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH  = 16;
  localparam int unsigned NUM_TB  = 2;
  localparam int unsigned TB_W    = 16;
  localparam int unsigned PRESC_W = 3;
  localparam int unsigned DIV_W   = 8;
  localparam int unsigned HALF_CH = 8;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]      STAG_LAST   = 3'h7;
  localparam logic [TB_W-1:0] TB_MAX      = 16'hFFFF;
  localparam logic [TB_W-1:0] TB_RESET    = 16'h0000;
  localparam logic [TB_W-1:0] RELOAD_RST  = 16'h0000;
  localparam logic [TB_W-1:0] CH_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // field positions of the capture edge select
  // ----------------------------------------------------------------
  localparam int unsigned EDGE_RISE_POS = 0;
  localparam int unsigned EDGE_FALL_POS = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCM_OFF, CCM_CAPTURE, CCM_CMP0, CCM_CMP1, CCM_CMP2, CCM_CMP3
  } ccm_mode_t;

  typedef enum logic [1:0] {
    CCM_CLK_PRESC, CCM_CLK_GPT, CCM_CLK_EXT
  } ccm_clk_t;

  // last prescaler count for a divide by 2**presc
  function automatic logic [DIV_W-1:0] presc_last(input logic [PRESC_W-1:0] presc);
    presc_last = DIV_W'((9'h001 << presc) - 9'h001);
  endfunction

  function automatic logic is_compare(input ccm_mode_t m);
    is_compare = (m == CCM_CMP0) || (m == CCM_CMP1) || (m == CCM_CMP2) || (m == CCM_CMP3);
  endfunction
endpackage
`default_nettype wire

// *** ccm_time_base.sv ***
// one 16-bit time base with prescaler and reload register
`default_nettype none
module ccm_time_base (
  input  wire logic                        i_clk_sys,     // system clock
  input  wire logic                        i_rst_n,       // synchronised reset
  input  wire logic                        i_run,         // count enable
  input  wire logic [1:0]                  i_clk_sel,     // clock source
  input  wire logic [ccm_pkg::PRESC_W-1:0] i_presc,       // divide by 2**n
  input  wire logic                        i_stag_on,     // staggered operation
  input  wire logic                        i_stag_en,     // one pulse per 8 cycles
  input  wire logic                        i_gpt_ovf,     // general timer over/underflow
  input  wire logic                        i_ext_cnt,     // external count level
  input  wire logic                        i_reload_wr,   // reload register write
  input  wire logic [ccm_pkg::TB_W-1:0]    i_reload_data, // reload value
  output logic      [ccm_pkg::TB_W-1:0]    o_count,       // timer value
  output logic                             o_step,        // count changed last edge
  output logic                             o_ovf          // overflow happened last edge
);
  logic [ccm_pkg::DIV_W-1:0] div_reg;
  logic                      ext_prev_reg;
  logic [ccm_pkg::TB_W-1:0]  reload_reg;
  logic                      base_en;
  logic                      presc_tick;
  logic                      tick;

  // ----------------------------------------------------------------
  // clock source
  // ----------------------------------------------------------------
  // stagger slows prescaled ticks
  assign base_en    = i_stag_on ? i_stag_en : 1'b1;
  assign presc_tick = base_en && (div_reg == ccm_pkg::presc_last(i_presc));

  always_comb begin
    unique case (ccm_pkg::ccm_clk_t'(i_clk_sel))
      ccm_pkg::CCM_CLK_PRESC: tick = i_run && presc_tick;
      ccm_pkg::CCM_CLK_GPT:   tick = i_run && i_gpt_ovf;
      ccm_pkg::CCM_CLK_EXT:   tick = i_run && i_ext_cnt && !ext_prev_reg;
      default:                tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg      <= '0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= i_ext_cnt;
      if (!i_run) begin
        div_reg <= '0;
      end else if (base_en) begin
        div_reg <= presc_tick ? '0 : div_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter and reload
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reload_reg <= ccm_pkg::RELOAD_RST;
    end else if (i_reload_wr) begin
      reload_reg <= i_reload_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= ccm_pkg::TB_RESET;
      o_step  <= 1'b0;
      o_ovf   <= 1'b0;
    end else begin
      o_step <= tick;
      o_ovf  <= tick && (o_count == ccm_pkg::TB_MAX);
      if (tick) begin
        o_count <= (o_count == ccm_pkg::TB_MAX) ? reload_reg : o_count + 1'b1;
      end
    end
  end

  ovf_reload_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tick && (o_count == ccm_pkg::TB_MAX) |=> o_ovf && (o_count == $past(reload_reg)))
    else $error("time base did not reload on overflow");
endmodule
`default_nettype wire

// *** ccm_capture_compare.sv ***
// sixteen channel capture/compare array with two time bases
// ----------------------------------------------------------------
// Overview of operation
// - sixteen capture/compare channels generate and time signal sequences
// - resolution one clock, eight clocks when staggered operation is on
// - two independent 16-bit time bases, each with a reload register
// - time bases count prescaled clock or general timer overflow events
// - time base a can also count external count input edges
// - each channel picks a time base and capture or compare function
// - one pin per channel: capture trigger input or compare output
// - capture latches the assigned time base value into the channel
// - each capture raises that channel's interrupt request
// - capture edge per channel: rising, falling or both
// - compare channels match register against time base and act
// - mode 0: interrupt only, pin untouched, many per period
// - mode 1: pin toggles on every match, many per period
// - mode 2: interrupt only, at most one per period
// - mode 3: match sets pin, overflow clears it, once per period
// - double register mode: two registers toggle one shared pin
// - single event option gives only one edge or pulse
// ----------------------------------------------------------------
`default_nettype none
module ccm_capture_compare (
  input  wire logic                          i_clk_sys,      // 125 MHz system clock
  input  wire logic                          i_nrst,         // async reset, active low
  input  wire logic [1:0]                    i_tb_run,       // time base count enables
  input  wire logic [1:0][1:0]               i_tb_clk_sel,   // clock source per base
  input  wire logic [1:0][2:0]               i_tb_presc,     // prescaler per base
  input  wire logic                          i_stag_on,      // staggered operation
  input  wire logic                          i_gpt_ovf,      // general timer ovf pulse
  input  wire logic                          i_ext_cnt,      // external count, base a
  input  wire logic [1:0]                    i_reload_wr,    // reload write strobes
  input  wire logic [15:0]                   i_reload_data,  // reload write data
  input  wire logic [15:0][2:0]              i_ch_mode,      // channel mode
  input  wire logic [15:0]                   i_ch_sel_b,     // 1: time base b
  input  wire logic [15:0][1:0]              i_ch_edge,      // capture edge select
  input  wire logic [15:0]                   i_ch_single,    // single event option
  input  wire logic [7:0]                    i_dbl_en,       // pair n with n+8
  input  wire logic                          i_ch_wr,        // channel register write
  input  wire logic [3:0]                    i_ch_wr_idx,    // channel to write
  input  wire logic [15:0]                   i_ch_wr_data,   // value to write
  input  wire logic [15:0]                   i_ch_pin,       // pin levels
  output logic      [15:0]                   o_ch_pin,       // pin drive levels
  output logic      [15:0]                   o_ch_pin_oe_n,  // low: pin driven
  output logic      [15:0]                   o_ch_irq,       // channel irq pulses
  output logic      [15:0][15:0]             o_ch_value,     // channel registers
  output logic      [1:0][15:0]              o_tb_count,     // time base values
  output logic      [1:0]                    o_tb_ovf        // time base ovf pulses
);
  // ----------------------------------------------------------------
  // reset synchroniser and stagger divider
  // ----------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n_reg;
  logic [2:0] stag_cnt_reg;
  logic       stag_en_reg;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      stag_cnt_reg <= '0;
      stag_en_reg  <= 1'b0;
    end else begin
      stag_cnt_reg <= stag_cnt_reg + 1'b1;
      stag_en_reg  <= (stag_cnt_reg == ccm_pkg::STAG_LAST);
    end
  end

  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  logic [1:0] tb_step;
  logic [1:0] ext_in;

  // only base a sees the count input
  assign ext_in = {1'b0, i_ext_cnt};

  for (genvar t = 0; t < ccm_pkg::NUM_TB; t++) begin : gen_tb
    ccm_time_base u_tb (
      .i_clk_sys     (i_clk_sys),
      .i_rst_n       (rst_n_reg),
      .i_run         (i_tb_run[t]),
      .i_clk_sel     (i_tb_clk_sel[t]),
      .i_presc       (i_tb_presc[t]),
      .i_stag_on     (i_stag_on),
      .i_stag_en     (stag_en_reg),
      .i_gpt_ovf     (i_gpt_ovf),
      .i_ext_cnt     (ext_in[t]),
      .i_reload_wr   (i_reload_wr[t]),
      .i_reload_data (i_reload_data),
      .o_count       (o_tb_count[t]),
      .o_step        (tb_step[t]),
      .o_ovf         (o_tb_ovf[t])
    );
  end

  // ----------------------------------------------------------------
  // per channel decode
  // ----------------------------------------------------------------
  // sixteen channel registers
  logic [15:0][15:0] ch_value_reg;
  logic [15:0]       pin_prev_reg;
  logic [15:0]       period_done_reg;
  logic [15:0]       single_done_reg;
  logic [15:0]       cap_evt;
  logic [15:0]       match;
  logic [15:0]       ovf_sel;
  logic [15:0]       one_per;
  logic [15:0]       fire;
  logic [15:0]       pin_next;
  logic [15:0]       oe_n_next;

  assign o_ch_value = ch_value_reg;

  always_comb begin
    for (int i = 0; i < ccm_pkg::NUM_CH; i++) begin
      ccm_pkg::ccm_mode_t m;
      logic               s;
      logic               rise;
      logic               fall;
      m    = ccm_pkg::ccm_mode_t'(i_ch_mode[i]);
      s    = i_ch_sel_b[i];
      rise = i_ch_pin[i] && !pin_prev_reg[i];
      fall = !i_ch_pin[i] && pin_prev_reg[i];
      cap_evt[i] = (m == ccm_pkg::CCM_CAPTURE) &&
                   ((rise && i_ch_edge[i][ccm_pkg::EDGE_RISE_POS]) ||
                    (fall && i_ch_edge[i][ccm_pkg::EDGE_FALL_POS]));
      ovf_sel[i] = o_tb_ovf[s];
      one_per[i] = (m == ccm_pkg::CCM_CMP2) || (m == ccm_pkg::CCM_CMP3);
      // compare on each new time base value
      match[i]   = ccm_pkg::is_compare(m) && tb_step[s] &&
                   (o_tb_count[s] == ch_value_reg[i]) &&
                   !(i_ch_single[i] && single_done_reg[i]) &&
                   !(one_per[i] && period_done_reg[i]);
    end
  end

  // ----------------------------------------------------------------
  // pin actions
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ccm_pkg::NUM_CH; i++) begin
      ccm_pkg::ccm_mode_t m;
      logic               paired_lo;
      logic               paired_hi;
      m         = ccm_pkg::ccm_mode_t'(i_ch_mode[i]);
      paired_lo = (i < ccm_pkg::HALF_CH) && i_dbl_en[i % ccm_pkg::HALF_CH];
      paired_hi = (i >= ccm_pkg::HALF_CH) && i_dbl_en[i % ccm_pkg::HALF_CH];
      pin_next[i]  = o_ch_pin[i];
      oe_n_next[i] = 1'b1;
      fire[i]      = match[i];
      if (paired_lo) begin
        // either register toggles the low pin
        // modulo only keeps the static index in range
        fire[i]      = match[i] || match[(i + ccm_pkg::HALF_CH) % ccm_pkg::NUM_CH];
        oe_n_next[i] = 1'b0;
        if (fire[i]) begin
          pin_next[i] = !o_ch_pin[i];
        end
      end else if (paired_hi) begin
        // pin of upper partner stays free in double mode
        oe_n_next[i] = 1'b1;
      end else if (m == ccm_pkg::CCM_CMP1) begin
        oe_n_next[i] = 1'b0;
        if (match[i]) begin
          pin_next[i] = !o_ch_pin[i];
        end
      end else if (m == ccm_pkg::CCM_CMP3) begin
        oe_n_next[i] = 1'b0;
        // set on match, overflow clears; set wins
        if (match[i]) begin
          pin_next[i] = 1'b1;
        end else if (ovf_sel[i]) begin
          pin_next[i] = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ch_value_reg <= {ccm_pkg::NUM_CH{ccm_pkg::CH_RESET}};
      pin_prev_reg <= '0;
    end else begin
      pin_prev_reg <= i_ch_pin;
      for (int i = 0; i < ccm_pkg::NUM_CH; i++) begin
        if (cap_evt[i]) begin
          ch_value_reg[i] <= o_tb_count[i_ch_sel_b[i]];
        end else if (i_ch_wr && (i_ch_wr_idx == 4'(i))) begin
          ch_value_reg[i] <= i_ch_wr_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // period and single event tracking
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      period_done_reg <= '0;
    end else begin
      for (int i = 0; i < ccm_pkg::NUM_CH; i++) begin
        // one event per period; a match in the ovf cycle keeps it
        if (match[i] && one_per[i]) begin
          period_done_reg[i] <= 1'b1;
        end else if (ovf_sel[i]) begin
          period_done_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      single_done_reg <= '0;
    end else begin
      for (int i = 0; i < ccm_pkg::NUM_CH; i++) begin
        // mode 3 ends its pulse on overflow, others on the match
        if (ccm_pkg::ccm_mode_t'(i_ch_mode[i]) == ccm_pkg::CCM_CMP3 ?
            (ovf_sel[i] && o_ch_pin[i] && !match[i]) : match[i]) begin
          single_done_reg[i] <= 1'b1;
        end else if (!i_ch_single[i] ||
                     (i_ch_wr && (i_ch_wr_idx == 4'(i)))) begin
          // rearmed by clearing the option or rewriting the register
          single_done_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_ch_pin      <= '0;
      o_ch_pin_oe_n <= '1;
      o_ch_irq      <= '0;
    end else begin
      o_ch_pin      <= pin_next;
      o_ch_pin_oe_n <= oe_n_next;
      o_ch_irq      <= cap_evt | match;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence stag_step_s;
    tb_step[0] && i_stag_on && (i_tb_clk_sel[0] == 2'h0) && $stable(i_stag_on);
  endsequence

  stagger_gap_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
    stag_step_s |=> (!tb_step[0] || !i_stag_on || i_tb_clk_sel[0] != 2'h0)[*7])
    else $error("staggered time base stepped too early");

  for (genvar g = 0; g < ccm_pkg::NUM_CH; g++) begin : gen_chk
    sequence cap_s;
      cap_evt[g] && !(i_ch_wr && i_ch_wr_idx == 4'(g));
    endsequence

    capture_latch_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      cap_s |=> (o_ch_value[g] == $past(o_tb_count[i_ch_sel_b[g]])))
      else $error("capture did not latch the time base");

    capture_irq_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      cap_evt[g] |=> o_ch_irq[g])
      else $error("capture raised no interrupt");

    capture_edge_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      i_ch_mode[g] == 3'(ccm_pkg::CCM_CAPTURE) && $changed(i_ch_pin[g]) &&
      (i_ch_pin[g] ? i_ch_edge[g][ccm_pkg::EDGE_RISE_POS] :
                     i_ch_edge[g][ccm_pkg::EDGE_FALL_POS]) |=> o_ch_irq[g])
      else $error("selected capture edge raised no interrupt");

    pin_drive_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      i_ch_mode[g] == 3'(ccm_pkg::CCM_CAPTURE) && !i_dbl_en[g % 8] |=> o_ch_pin_oe_n[g])
      else $error("capture channel drove its pin");

    cmp0_pin_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      match[g] && i_ch_mode[g] == 3'(ccm_pkg::CCM_CMP0) && !i_dbl_en[g % 8]
      |=> o_ch_irq[g] && $stable(o_ch_pin[g]))
      else $error("mode 0 match touched the pin");

    cmp1_toggle_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      match[g] && i_ch_mode[g] == 3'(ccm_pkg::CCM_CMP1) && !i_dbl_en[g % 8]
      |=> o_ch_pin[g] != $past(o_ch_pin[g]))
      else $error("mode 1 match did not toggle the pin");

    cmp2_once_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      period_done_reg[g] && !ovf_sel[g] && i_ch_mode[g] == 3'(ccm_pkg::CCM_CMP2)
      |-> !match[g])
      else $error("mode 2 fired twice in one period");

    cmp3_set_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      match[g] && i_ch_mode[g] == 3'(ccm_pkg::CCM_CMP3) && !i_dbl_en[g % 8]
      |=> o_ch_pin[g] ##1 1'b1)
      else $error("mode 3 match did not set the pin");

    cmp3_clear_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      ovf_sel[g] && !match[g] && i_ch_mode[g] == 3'(ccm_pkg::CCM_CMP3) && !i_dbl_en[g % 8]
      |=> !o_ch_pin[g])
      else $error("mode 3 overflow did not clear the pin");

    period_restart_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      ovf_sel[g] && !(match[g] && one_per[g]) |=> !period_done_reg[g])
      else $error("overflow did not open a new period");

    single_stop_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
      single_done_reg[g] && i_ch_single[g] |-> !match[g])
      else $error("single event channel fired again");

    if (g < 8) begin : gen_dbl
      dbl_toggle_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        i_dbl_en[g] && (match[g] || match[g + 8]) |=> o_ch_pin[g] != $past(o_ch_pin[g]))
        else $error("double register match did not toggle");

      dbl_hi_free_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        i_dbl_en[g] |=> o_ch_pin_oe_n[g + 8])
        else $error("upper pin of a register pair was driven");
    end
  end
endmodule
`default_nettype wire

// *** ccm_pin_model.sv ***
// pin wire model: block drive against the outside driver
`default_nettype none
module ccm_pin_model (
  input  wire logic [15:0] i_drive, // block drive levels
  input  wire logic [15:0] i_oe_n,  // low: block drives
  input  wire logic [15:0] i_ext,   // outside driver level
  output logic      [15:0] o_wire   // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      o_wire[k] = i_oe_n[k] ? i_ext[k] : i_drive[k];
    end
  end
endmodule
`default_nettype wire

// *** ccm_capture_compare_bench.sv ***
// self-checking bench for the capture/compare array
`default_nettype none
module ccm_capture_compare_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, stag, gpt, ext, wr;
  logic [1:0] tb_run, rl_wr, ovf;
  logic [1:0][1:0] clk_sel;
  logic [1:0][2:0] presc;
  logic [15:0] rl_d, sel_b, single, wr_d, pin_in, pin_o, oe_n, irq, ext_lvl;
  logic [15:0][2:0] mode;
  logic [15:0][1:0] edge_s;
  logic [15:0][15:0] val;
  logic [1:0][15:0] cnt;
  logic [7:0] dbl;
  logic [3:0] wr_idx;
  int errors, checks_done;

  ccm_capture_compare uut (.i_clk_sys(clk), .i_nrst(nrst), .i_tb_run(tb_run),
    .i_tb_clk_sel(clk_sel), .i_tb_presc(presc), .i_stag_on(stag), .i_gpt_ovf(gpt),
    .i_ext_cnt(ext), .i_reload_wr(rl_wr), .i_reload_data(rl_d), .i_ch_mode(mode),
    .i_ch_sel_b(sel_b), .i_ch_edge(edge_s), .i_ch_single(single), .i_dbl_en(dbl),
    .i_ch_wr(wr), .i_ch_wr_idx(wr_idx), .i_ch_wr_data(wr_d), .i_ch_pin(pin_in),
    .o_ch_pin(pin_o), .o_ch_pin_oe_n(oe_n), .o_ch_irq(irq), .o_ch_value(val),
    .o_tb_count(cnt), .o_tb_ovf(ovf));
  ccm_pin_model pins (.i_drive(pin_o), .i_oe_n(oe_n), .i_ext(ext_lvl), .o_wire(pin_in));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr_ch(input logic [3:0] idx, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    wr_idx = idx;
    wr_d = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // counts irq pulses and pin changes; c_at is base a count at an irq
  task automatic watch(input int ch, input int n, output int irqs, output int tog,
                       output logic [15:0] c_at);
    logic p;
    irqs = 0;
    tog = 0;
    c_at = 16'h0000;
    p = pin_o[ch];
    repeat (n) begin
      @(negedge clk);
      if (irq[ch] === 1'b1) begin
        irqs++;
        c_at = cnt[0];
      end
      if (pin_o[ch] !== p) tog++;
      p = pin_o[ch];
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_period;
    int n;
    @(negedge clk);
    rl_wr = 2'b11;
    rl_d = 16'hFFF0;
    tb_run = 2'b11;
    @(negedge clk);
    rl_wr = 2'b00;
    n = 0;
    while (ovf[0] !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    check(cnt[0], 16'hFFF0);
    $display("period test done");
  endtask

  task automatic t_cmp;
    int i, t;
    logic [15:0] c;
    ccm_pkg::ccm_mode_t md[4] = '{ccm_pkg::CCM_CMP0, ccm_pkg::CCM_CMP1,
                                  ccm_pkg::CCM_CMP2, ccm_pkg::CCM_CMP3};
    wr_ch(4'h3, 16'hFFF8);
    for (int m = 0; m < 4; m++) begin
      mode[3] = md[m];
      watch(3, 16, i, t, c);
      watch(3, 32, i, t, c);
      check(i, 2);
      check(c, 16'hFFF9);
      check(t, (m == 1) ? 2 : (m == 3) ? 4 : 0);
      if (m != 1 && m != 3) check(oe_n[3], 1'b1);
    end
    // a rewrite after a mode 2 event stays quiet until the next period
    mode[3] = ccm_pkg::CCM_CMP2;
    wr_ch(4'h3, 16'hFFF4);
    // skip a pulse left from the old value
    @(negedge clk);
    for (int n = 0; n < 40 && irq[3] !== 1'b1; n++) begin
      @(negedge clk);
    end
    check(irq[3], 1'b1);
    wr_ch(4'h3, 16'hFFFA);
    watch(3, 6, i, t, c);
    check(i, 0);
    mode[3] = ccm_pkg::CCM_OFF;
    $display("compare test done");
  endtask

  task automatic t_single;
    int i, t;
    logic [15:0] c;
    mode[5] = ccm_pkg::CCM_CMP1;
    single[5] = 1'b1;
    wr_ch(4'h5, 16'hFFF8);
    watch(5, 48, i, t, c);
    check(t, 1);
    wr_ch(4'h5, 16'hFFF8);
    watch(5, 48, i, t, c);
    check(t, 1);
    $display("single test done");
  endtask

  task automatic t_double;
    int i, t;
    logic [15:0] c;
    dbl[2] = 1'b1;
    mode[2] = ccm_pkg::CCM_CMP1;
    mode[10] = ccm_pkg::CCM_CMP1;
    wr_ch(4'h2, 16'hFFF2);
    wr_ch(4'hA, 16'hFFFA);
    watch(2, 16, i, t, c);
    watch(2, 32, i, t, c);
    check(t, 4);
    check(oe_n[10], 1'b1);
    $display("double test done");
  endtask

  task automatic t_capture;
    int i, j, t;
    logic [15:0] c, cb;
    mode[6] = ccm_pkg::CCM_CAPTURE;
    sel_b[6] = 1'b1;
    tb_run[1] = 1'b0;
    repeat (3) @(negedge clk);
    cb = cnt[1];
    for (int e = 1; e < 4; e++) begin
      edge_s[6] = 2'(e);
      wr_ch(4'h6, 16'h0000);
      ext_lvl[6] = 1'b1;
      watch(6, 4, i, t, c);
      ext_lvl[6] = 1'b0;
      watch(6, 4, j, t, c);
      check(i + j, (e == 3) ? 2 : 1);
      check(val[6], cb);
    end
    tb_run[1] = 1'b1;
    $display("capture test done");
  endtask

  task automatic t_clk;
    logic [15:0] c;
    @(negedge clk);
    rl_wr = 2'b10;
    rl_d = 16'h0000;
    @(negedge clk);
    rl_wr = 2'b00;
    repeat (40) @(negedge clk);
    stag = 1'b1;
    c = cnt[1];
    repeat (64) @(negedge clk);
    check(16'(cnt[1] - c), 8);
    stag = 1'b0;
    presc[1] = 3'h2;
    c = cnt[1];
    repeat (64) @(negedge clk);
    check(16'(cnt[1] - c), 16);
    clk_sel[1] = 2'h1;
    c = cnt[1];
    repeat (5) begin
      gpt = 1'b1;
      @(negedge clk);
      gpt = 1'b0;
      @(negedge clk);
    end
    check(16'(cnt[1] - c), 5);
    clk_sel[0] = 2'h2;
    c = cnt[0];
    repeat (4) begin
      ext = 1'b1;
      @(negedge clk);
      ext = 1'b0;
      @(negedge clk);
    end
    check(16'((cnt[0] - c) & 16'h000F), 4);
    $display("clock source test done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {stag, gpt, ext, wr, tb_run, rl_wr, clk_sel, presc} = '0;
    {rl_d, sel_b, single, wr_d, ext_lvl, mode, edge_s, dbl, wr_idx} = '0;
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    check(oe_n, 16'hFFFF);
    check(irq, 16'h0000);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_period();
    t_cmp();
    t_single();
    t_double();
    t_capture();
    t_clk();
    finish_test();
  end

  // whole run is about 66k cycles
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
